// >>> apb_sequencer_model.sv
`timescale 1ns/1ps

// ****************************************
// requester issuing apb transfers
// ****************************************
module apb_sequencer_model (
  input  wire logic        pclk,    // clock
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr, // error
  output logic             psel,    // select
  output logic             penable, // enable
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // address
  output logic      [31:0] pwdata   // write data
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule

// >>> digit_encode_convert_checker.sv
`timescale 1ns/1ps

// ****************************************
// port checker
// ****************************************
module digit_encode_convert_checker (
  input wire logic        pclk,       // clock
  input wire logic        presetn,    // async reset, low active
  input wire logic        ce,         // clock enable
  input wire logic        psel,       // apb select
  input wire logic        penable,    // apb enable
  input wire logic        pwrite,     // apb direction
  input wire logic [11:0] paddr,      // apb address
  input wire logic [31:0] pwdata,     // apb write data
  input wire logic [31:0] prdata,     // apb read data
  input wire logic        pready,     // apb ready
  input wire logic        pslverr,    // apb error
  input wire logic        error_flag, // operation error
  input wire logic        irq         // interrupt
);
  logic [15:0] desig_r;
  wire         done_w  = ce && psel && penable && pready;
  wire         ctrl_go = done_w && pwrite && paddr == 12'h000 && pwdata[0];
  wire         des_wr  = done_w && pwrite && paddr == 12'h004;
  wire         acc_w   = psel && penable;
  wire         wr_done = done_w && pwrite;
  wire         go_exec = ctrl_go && pwdata[3];
  wire         stat_rd = done_w && !pwrite && paddr == 12'h02c;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desig_r <= 16'h0000;
    end else if (des_wr) begin
      desig_r <= pwdata[15:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait;
    ce && psel && penable && !pready;
  endsequence
  sequence s_exec_go;
    go_exec;
  endsequence
  sequence s_seg_bad;
    pwdata[2:1] == 2'h2 && (desig_r[3:0] > 4'h3 || desig_r[11:8] > 4'h1);
  endsequence
  sequence s_prio_bad;
    pwdata[2:1] == 2'h1 && (desig_r[3:0] > 4'h3 || desig_r[7:4] > 4'h3);
  endsequence

  AST_READY_LAT: assert property (s_wait |=> pready)
    else $error("pready missing one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_READY_CAUSE: assert property ($rose(pready) |-> $past(acc_w))
    else $error("pready without access phase");
  AST_SLVERR_ADDR: assert property (pslverr |-> pready && (paddr > 12'h034 || paddr[1:0] != 2'h0))
    else $error("pslverr on mapped address");
  AST_EXEC_LOW: assert property (ctrl_go && !pwdata[3] |=> $stable(error_flag))
    else $error("error flag moved with condition low");
  AST_ERR_CAUSE: assert property ($changed(error_flag) |-> $past(go_exec))
    else $error("error flag moved without operation");
  AST_SEG_BAD: assert property (s_exec_go ##0 s_seg_bad |=> error_flag)
    else $error("bad segment designator not flagged");
  AST_PRIO_BAD: assert property (s_exec_go ##0 s_prio_bad |=> error_flag)
    else $error("bad encode designator not flagged");
  AST_STAT_MIRROR: assert property (stat_rd |-> prdata[0] == error_flag)
    else $error("status read differs from error flag");
  AST_IRQ_DELAY: assert property ($rose(irq) |-> $past(wr_done))
    else $error("irq rose without a completed write one cycle before");
endmodule

// >>> digit_encode_convert_map.svh
`ifndef DIGIT_ENCODE_CONVERT_MAP_SVH
`define DIGIT_ENCODE_CONVERT_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define DEC_OFF_CTRL     12'h000
`define DEC_OFF_DESIG    12'h004
`define DEC_OFF_AREA     12'h008
`define DEC_OFF_SRC0     12'h00c
`define DEC_OFF_SRC1     12'h010
`define DEC_OFF_SRC2     12'h014
`define DEC_OFF_SRC3     12'h018
`define DEC_OFF_RES      12'h01c
`define DEC_OFF_DST0     12'h020
`define DEC_OFF_DST1     12'h024
`define DEC_OFF_DST2     12'h028
`define DEC_OFF_STAT     12'h02c
`define DEC_OFF_INT_STAT 12'h030
`define DEC_OFF_INT_MASK 12'h034

// ****************************************
// field positions
// ****************************************
`define DEC_CTRL_GO      0
`define DEC_CTRL_OP_LO   1
`define DEC_CTRL_EXEC    3
`define DEC_AREA_SRC_LO  0
`define DEC_AREA_DST_LO  8
`define DEC_INT_DONE     0
`define DEC_INT_ERR      1

// ****************************************
// reset values
// ****************************************
`define DEC_RST_AREA_SRC 3'h4
`define DEC_RST_AREA_DST 3'h3
`define DEC_RST_WORD     16'h0000

`endif

// >>> digit_encode_convert_pkg.sv
package digit_encode_convert_pkg;

  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_PRIO   = 2'b01,
    OP_SEG    = 2'b10,
    OP_ASCII  = 2'b11
  } op_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_EVEN = 2'b01,
    PAR_ODD  = 2'b10
  } parity_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK  = 1'b1
  } apb_st_t;

endpackage

// >>> digit_encode_convert_unit.sv
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "digit_encode_convert_map.svh"


module digit_encode_convert_unit (
  input  wire logic        pclk,       // clock
  input  wire logic        presetn,    // async reset, low active
  input  wire logic        ce,         // clock enable
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb enable
  input  wire logic        pwrite,     // apb direction
  input  wire logic [11:0] paddr,      // apb address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error
  output logic             error_flag, // error of last operation
  output logic             irq         // interrupt
);

  // ****************************************
  // state
  // ****************************************
  digit_encode_convert_pkg::apb_st_t st_r;
  digit_encode_convert_pkg::op_t     op_r;
  logic        exec_r;
  logic [15:0] desig_r;
  logic [2:0]  src_room_r;
  logic [2:0]  dst_room_r;
  logic [15:0] src_r [4];
  logic [15:0] res_r;
  logic [15:0] dst_r [3];
  logic [1:0]  int_stat_r;
  logic [1:0]  int_mask_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        error_r;
  logic        irq_r;

  // ****************************************
  // bus decode
  // ****************************************
  wire access  = psel && penable;
  wire take    = access && (st_r == digit_encode_convert_pkg::ST_ACK);
  wire wr_take = take && pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire h_ctrl  = hit(paddr, `DEC_OFF_CTRL);
  wire h_desig = hit(paddr, `DEC_OFF_DESIG);
  wire h_area  = hit(paddr, `DEC_OFF_AREA);
  wire h_src0  = hit(paddr, `DEC_OFF_SRC0);
  wire h_src1  = hit(paddr, `DEC_OFF_SRC1);
  wire h_src2  = hit(paddr, `DEC_OFF_SRC2);
  wire h_src3  = hit(paddr, `DEC_OFF_SRC3);
  wire h_res   = hit(paddr, `DEC_OFF_RES);
  wire h_dst0  = hit(paddr, `DEC_OFF_DST0);
  wire h_dst1  = hit(paddr, `DEC_OFF_DST1);
  wire h_dst2  = hit(paddr, `DEC_OFF_DST2);
  wire h_stat  = hit(paddr, `DEC_OFF_STAT);
  wire h_ist   = hit(paddr, `DEC_OFF_INT_STAT);
  wire h_imsk  = hit(paddr, `DEC_OFF_INT_MASK);
  wire mapped  = h_ctrl | h_desig | h_area | h_src0 | h_src1 | h_src2 | h_src3
               | h_res | h_dst0 | h_dst1 | h_dst2 | h_stat | h_ist | h_imsk;

  wire [31:0] rd_mux =
      h_ctrl  ? {28'h0, exec_r, op_r, 1'b0} :
      h_desig ? {16'h0, desig_r} :
      h_area  ? {21'h0, dst_room_r, 5'h0, src_room_r} :
      h_src0  ? {16'h0, src_r[0]} :
      h_src1  ? {16'h0, src_r[1]} :
      h_src2  ? {16'h0, src_r[2]} :
      h_src3  ? {16'h0, src_r[3]} :
      h_res   ? {16'h0, res_r} :
      h_dst0  ? {16'h0, dst_r[0]} :
      h_dst1  ? {16'h0, dst_r[1]} :
      h_dst2  ? {16'h0, dst_r[2]} :
      h_stat  ? {31'h0, error_r} :
      h_ist   ? {30'h0, int_stat_r} :
      h_imsk  ? {30'h0, int_mask_r} : 32'h0000_0000;

  // ****************************************
  // operation start
  // ****************************************
  wire go = wr_take && h_ctrl && pwdata[`DEC_CTRL_GO];
  wire [1:0] go_op   = pwdata[`DEC_CTRL_OP_LO +: 2];
  wire       go_exec = pwdata[`DEC_CTRL_EXEC];
  wire       run     = go && go_exec &&
                       (go_op != 2'(digit_encode_convert_pkg::OP_NONE));

  // ****************************************
  // designator fields
  // ****************************************
  wire [1:0] first = desig_r[1:0];
  wire [1:0] cnt   = desig_r[5:4];   // count minus one
  wire       half  = desig_r[8];
  wire [1:0] par   = desig_r[13:12];
  wire low_ok   = (desig_r[3:2] == 2'b00) && (desig_r[7:6] == 2'b00);
  wire prio_ok  = low_ok && (desig_r[15:8] == 8'h00);
  wire seg_ok   = low_ok && (desig_r[11:9] == 3'h0) && (desig_r[15:12] == 4'h0);
  wire asc_ok   = low_ok && (desig_r[11:9] == 3'h0) && (desig_r[15:14] == 2'b00)
                && (par != 2'b11);

  // ****************************************
  // lanes
  // ****************************************
  logic [7:0] seg_l [4];
  logic [7:0] asc_l [4];
  logic [3:0] msb_l [4];
  logic [1:0] pos_l [4];
  logic       zero_l [4];

  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign pos_l[i] = first + 2'(i);
    digit_lut u_lut (
      .nibble (src_r[0][pos_l[i]*4 +: 4]),
      .word   (src_r[i]),
      .par    (par),
      .seg    (seg_l[i]),
      .ascii_convert_op    (asc_l[i]),
      .msb    (msb_l[i]),
      .zero   (zero_l[i])
    );
  end

  // ****************************************
  // results and errors
  // ****************************************
  wire [2:0] src_need  = {1'b0, cnt} + 3'h1;
  wire [2:0] last_byte = {2'b00, half} + {1'b0, cnt};
  wire [2:0] dst_need  = {1'b0, last_byte[2:1]} + 3'h1;

  digit_encode_convert_pkg::op_t op_sel;
  assign op_sel = digit_encode_convert_pkg::op_t'(go_op);

  logic        any_zero;
  logic [15:0] res_nxt;
  logic [47:0] dst_nxt;

  always_comb begin
    any_zero = 1'b0;
    res_nxt  = res_r;
    dst_nxt  = {dst_r[2], dst_r[1], dst_r[0]};
    for (int i = 0; i < 4; i++) begin
      if (i <= int'(cnt)) begin
        any_zero = any_zero | zero_l[i];
        res_nxt[pos_l[i]*4 +: 4] = msb_l[i];
        if (op_sel == digit_encode_convert_pkg::OP_SEG) begin
          dst_nxt[(int'(half) + i)*8 +: 8] = seg_l[i];
        end else begin
          dst_nxt[(int'(half) + i)*8 +: 8] = asc_l[i];
        end
      end
    end
  end

  wire prio_err = !prio_ok || (src_need > src_room_r) || any_zero;
  wire dst_err  = ((op_sel == digit_encode_convert_pkg::OP_SEG) ? !seg_ok : !asc_ok)
                || (dst_need > dst_room_r);
  wire is_prio  = (op_sel == digit_encode_convert_pkg::OP_PRIO);
  wire op_err   = is_prio ? prio_err : dst_err;

  // ****************************************
  // bus handshake
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= digit_encode_convert_pkg::ST_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      case (st_r)
        digit_encode_convert_pkg::ST_IDLE: begin
          if (access) begin
            st_r      <= digit_encode_convert_pkg::ST_ACK;
            pready_r  <= 1'b1;
            pslverr_r <= !mapped;
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
          end
        end
        digit_encode_convert_pkg::ST_ACK: begin
          st_r      <= digit_encode_convert_pkg::ST_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
        end
        default: st_r <= digit_encode_convert_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r       <= digit_encode_convert_pkg::OP_NONE;
      exec_r     <= 1'b0;
      desig_r    <= `DEC_RST_WORD;
      src_room_r <= `DEC_RST_AREA_SRC;
      dst_room_r <= `DEC_RST_AREA_DST;
      int_mask_r <= 2'b00;
      for (int i = 0; i < 4; i++) src_r[i] <= `DEC_RST_WORD;
    end else if (ce && wr_take) begin
      if (h_ctrl) begin
        op_r   <= op_sel;
        exec_r <= go_exec;
      end
      if (h_desig) desig_r <= pwdata[15:0];
      if (h_area) begin
        src_room_r <= pwdata[`DEC_AREA_SRC_LO +: 3];
        dst_room_r <= pwdata[`DEC_AREA_DST_LO +: 3];
      end
      if (h_src0) src_r[0] <= pwdata[15:0];
      if (h_src1) src_r[1] <= pwdata[15:0];
      if (h_src2) src_r[2] <= pwdata[15:0];
      if (h_src3) src_r[3] <= pwdata[15:0];
      if (h_imsk) int_mask_r <= pwdata[1:0];
    end
  end

  // ****************************************
  // result words
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r <= `DEC_RST_WORD;
      for (int i = 0; i < 3; i++) dst_r[i] <= `DEC_RST_WORD;
    end else if (ce) begin
      if (run && !op_err && is_prio) begin
        res_r <= res_nxt;
      end else if (wr_take && h_res) begin
        res_r <= pwdata[15:0];
      end
      if (run && !op_err && !is_prio) begin
        dst_r[0] <= dst_nxt[15:0];
        dst_r[1] <= dst_nxt[31:16];
        dst_r[2] <= dst_nxt[47:32];
      end else if (wr_take) begin
        if (h_dst0) dst_r[0] <= pwdata[15:0];
        if (h_dst1) dst_r[1] <= pwdata[15:0];
        if (h_dst2) dst_r[2] <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // flags and interrupt
  // ****************************************
  wire [1:0] ev  = {run && op_err, run};
  wire [1:0] w1c = (wr_take && h_ist) ? pwdata[1:0] : 2'b00;
  wire [1:0] ist_nxt = (int_stat_r & ~w1c) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_r    <= 1'b0;
      int_stat_r <= 2'b00;
      irq_r      <= 1'b0;
    end else if (ce) begin
      if (run) error_r <= op_err;
      int_stat_r <= ist_nxt;
      irq_r      <= |(ist_nxt & int_mask_r);
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign error_flag = error_r;
  assign irq        = irq_r;

endmodule

// >>> digit_lut.sv
`timescale 1ns/1ps

// ****************************************
// per-lane code generation
// ****************************************
module digit_lut (
  input  wire logic [3:0]  nibble,    // source digit
  input  wire logic [15:0] word,      // source word for encoding
  input  wire logic [1:0]  par,       // parity mode
  output logic      [7:0]  seg,       // segment code
  output logic      [7:0]  ascii_convert_op,       // ascii code
  output logic      [3:0]  msb,       // highest set bit number
  output logic             zero       // word holds no set bit
);

  logic [6:0] seg7;
  logic [6:0] asc7;
  logic       odd7;

  always_comb begin
    case (nibble)
      4'h0:    seg7 = 7'h3f;
      4'h1:    seg7 = 7'h06;
      4'h2:    seg7 = 7'h5b;
      4'h3:    seg7 = 7'h4f;
      4'h4:    seg7 = 7'h66;
      4'h5:    seg7 = 7'h6d;
      4'h6:    seg7 = 7'h7d;
      4'h7:    seg7 = 7'h27;
      4'h8:    seg7 = 7'h7f;
      4'h9:    seg7 = 7'h6f;
      4'ha:    seg7 = 7'h77;
      4'hb:    seg7 = 7'h7c;
      4'hc:    seg7 = 7'h39;
      4'hd:    seg7 = 7'h5e;
      4'he:    seg7 = 7'h79;
      default: seg7 = 7'h71;
    endcase
  end

  assign seg  = {1'b0, seg7};
  assign asc7 = (nibble < 4'ha) ? (7'h30 + {3'h0, nibble})
                                : (7'h37 + {3'h0, nibble});
  assign odd7 = ^asc7;
  assign ascii_convert_op  = {(par == 2'b01) ? odd7 :
                 (par == 2'b10) ? ~odd7 : 1'b0, asc7};

  always_comb begin
    msb = 4'h0;
    for (int b = 0; b < 16; b++) begin
      if (word[b]) begin
        msb = b[3:0];
      end
    end
  end

  assign zero = (word == 16'h0000);

endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "digit_encode_convert_map.svh"

module tb_top;
  localparam logic [7:0] SEG_TAB [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d,
    8'h27, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  localparam logic [15:0] SRC_TAB [2] = '{16'ha631, 16'hf9b0};
  logic        pclk = 1'b0;
  logic        presetn, ce, psel, penable, pwrite, pready, pslverr, error_flag, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #2.5 pclk = ~pclk;

  digit_encode_convert_unit dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .error_flag(error_flag), .irq(irq));
  apb_sequencer_model seq_u (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    seq_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    seq_u.xfer(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask
  task automatic op(input logic [15:0] dg, input logic [3:0] ctl);
    wr(`DEC_OFF_DESIG, {16'h0, dg});
    wr(`DEC_OFF_CTRL, {28'h0, ctl});
  endtask
  task automatic irq_is(input logic exp);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, exp});
    @(posedge pclk);
  endtask
  function automatic logic [7:0] asc_exp(input logic [3:0] n, input logic [1:0] p);
    logic [7:0] c;
    c = (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    c[7] = (p == 2'h1) ? ^c[6:0] : (p == 2'h2) ? ~^c[6:0] : 1'b0;
    return c;
  endfunction

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] q;
    logic        e;
    presetn = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DEC_OFF_AREA, 32'h0304);
    rd(`DEC_OFF_RES, 32'h0);
    seq_u.xfer(1'b0, 12'h040, 32'h0, q, e);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    wr(`DEC_OFF_INT_MASK, 32'h3);
    wr(`DEC_OFF_SRC0, 32'h8000);
    wr(`DEC_OFF_SRC1, 32'h0001);
    wr(`DEC_OFF_SRC2, 32'h0100);
    wr(`DEC_OFF_SRC3, 32'h0020);
    op(16'h0032, 4'hb);
    rd(`DEC_OFF_RES, 32'h0f58);
    rd(`DEC_OFF_STAT, 32'h0);
    irq_is(1'b1);
    rd(`DEC_OFF_INT_STAT, 32'h1);
    wr(`DEC_OFF_INT_STAT, 32'h3);
    irq_is(1'b0);
    wr(`DEC_OFF_SRC0, 32'h0001);
    op(16'h0032, 4'h3);
    rd(`DEC_OFF_RES, 32'h0f58);
    irq_is(1'b0);
    wr(`DEC_OFF_SRC1, 32'h0);
    op(16'h0010, 4'hb);
    rd(`DEC_OFF_RES, 32'h0f58);
    rd(`DEC_OFF_STAT, 32'h1);
    rd(`DEC_OFF_INT_STAT, 32'h3);
    wr(`DEC_OFF_SRC1, 32'h0001);
    wr(`DEC_OFF_AREA, 32'h0302);
    op(16'h0010, 4'hb);
    rd(`DEC_OFF_RES, 32'h0f00);
    op(16'h0020, 4'hb);
    rd(`DEC_OFF_STAT, 32'h1);
    wr(`DEC_OFF_AREA, 32'h0304);
    wr(`DEC_OFF_SRC0, 32'h0800);
    op(16'h0001, 4'hb);
    rd(`DEC_OFF_RES, 32'h0fb0);
    op(16'h0004, 4'hb);
    rd(`DEC_OFF_STAT, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`DEC_OFF_SRC0, {16'h0, 4'(4*i+3), 4'(4*i+2), 4'(4*i+1), 4'(4*i)});
      op(16'h0030, 4'hd);
      rd(`DEC_OFF_DST0, {16'h0, SEG_TAB[4*i+1], SEG_TAB[4*i]});
      rd(`DEC_OFF_DST1, {16'h0, SEG_TAB[4*i+3], SEG_TAB[4*i+2]});
    end
    wr(`DEC_OFF_DST0, 32'h0);
    wr(`DEC_OFF_DST2, 32'h0);
    wr(`DEC_OFF_SRC0, 32'h4321);
    op(16'h0133, 4'hd);
    rd(`DEC_OFF_DST0, 32'h6600);
    rd(`DEC_OFF_DST1, 32'h5b06);
    rd(`DEC_OFF_DST2, 32'h004f);
    wr(`DEC_OFF_AREA, 32'h0204);
    op(16'h0133, 4'hd);
    rd(`DEC_OFF_STAT, 32'h1);
    wr(`DEC_OFF_AREA, 32'h0304);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 3; p++) begin
        wr(`DEC_OFF_SRC0, {16'h0, SRC_TAB[s]});
        op({2'h0, 2'(p), 12'h030}, 4'hf);
        rd(`DEC_OFF_DST0, {16'h0, asc_exp(SRC_TAB[s][7:4], 2'(p)),
          asc_exp(SRC_TAB[s][3:0], 2'(p))});
        rd(`DEC_OFF_DST1, {16'h0, asc_exp(SRC_TAB[s][15:12], 2'(p)),
          asc_exp(SRC_TAB[s][11:8], 2'(p))});
      end
    end
    op(16'h0200, 4'hd);
    rd(`DEC_OFF_STAT, 32'h1);
    op(16'h0030, 4'hd);
    op(16'h3030, 4'hf);
    rd(`DEC_OFF_STAT, 32'h1);
    give_verdict();
  end
endmodule

bind digit_encode_convert_unit digit_encode_convert_checker chk_u (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .error_flag(error_flag), .irq(irq));
